// >>> pmbsc_top.v
// Purpose: Reset sampling, fetch-select strap, address-latch and fetch
//   strobes, idle and power-down control of an 8-bit controller core.
// Assumes: clk_in is the oscillator input; one divide-by-two enable forms
//   the internal phase clock.
// Notes: Address strobe is active high, fetch strobe active low; port 0 is open drain style.
//   The reset pin needs 24 clocks high, plus two synchroniser clocks.
// Function
// [R1] Reset after reset pin high two machine cycles
// [R2] Address strobe pulses at one sixth oscillator
// [R3] Skip one address strobe per data access
// [R4] Power bit five stops strobe, weak pull-up
// [R5] Disable suspended for data, table, idle, power-down
// [R6] Reset clears the address strobe disable
// [R7] Disable ignored during external code execution
// [R8] Fetch strobe twice per machine cycle externally
// [R9] Skip two fetch strobes per data access
// [R10] Latch fetch select at reset, hold it
// [R11] Fetch select low means all code external
// [R12] Port zero multiplexes low address then data
// [R13] Port two drives high address byte
// [R14] Indirect access keeps port two latch contents
// [R15] Internal clocking through divide-by-two stage
// [R16] Idle stops execution, keeps registers
// [R17] Idle exits on reset or enabled interrupt
// [R18] Idle strobes high, power-down strobes low
// [R19] Power-down stops oscillator, keeps state
// [R20] Reset or interrupt ends power-down
// [R21] Low level interrupt restarts, high completes
// [R22] Resume after the entering instruction
// [R23] Wake source held until oscillator settles
`timescale 1ns/10ps
`default_nettype none
`include "pmbsc_defines.vh"
module pmbsc_top #(
  parameter SETTLE_CYC = `PMBSC_SETTLE_CYC
)
(
  input wire clk_in, // Oscillator-rate clock
  input wire rst_in, // Synchronous system reset
  input wire reset_pin_in, // Device reset pin, async
  input wire external_fetch_select_in, // Strap, low = external code
  input wire ext_irq_zero_n_in, // External interrupt 0, low active
  input wire ext_irq_one_n_in, // External interrupt 1, low active
  input wire [15:0] pc_addr_in, // Code fetch address from core
  input wire [15:0] wide_pointer_reg_in, // Wide data pointer
  input wire [7:0] indirect_index_reg_in, // 8-bit data pointer
  input wire [7:0] port_two_latch_in, // Port two output latch value
  input wire [7:0] port_zero_latch_in, // Port zero output latch value
  input wire [7:0] write_data_in, // Data for external writes
  input wire [7:0] avs_address, // Avalon byte address
  input wire avs_read, // Avalon read
  input wire avs_write, // Avalon write
  input wire [31:0] avs_writedata, // Avalon write data
  input wire [3:0] avs_byteenable, // Avalon byte enables
  output reg [31:0] avs_readdata, // Avalon read data
  output reg avs_waitrequest, // Avalon wait request
  output reg address_latch_strobe_out, // Address latch strobe, high pulse
  output reg ale_weak_pull_out, // Weak pull-up active on strobe pin
  output reg program_fetch_strobe_n_out, // Fetch read strobe, low active
  output reg [7:0] port_zero_out, // Port 0 drive value
  output reg [7:0] port_zero_oe_n_out, // Port 0 enable, low drives
  output reg [7:0] port_two_out, // Port 2 drive value
  output reg core_run_out, // Instruction execution enable
  output reg osc_run_out, // Oscillator running
  output reg core_reset_out, // Register reset to core
  output reg wake_irq_out, // Wake interrupt request to core
  output reg external_exec_out // Latched external execution
);
////////////////////////////////////////////////////////////////////////
  localparam [1:0] MODE_RUN = 2'b00;
  localparam [1:0] MODE_IDLE = 2'b01;
  localparam [1:0] MODE_PDOWN = 2'b10;
  localparam [1:0] MODE_WAKE = 2'b11;
  localparam [4:0] RST_CYC = `PMBSC_RST_CYC;
  localparam [2:0] LAST_PHASE = `PMBSC_LAST_PHASE;

  reg rp_s1_q, rp_s2_q, i0_s1_q, i0_s2_q, i1_s1_q, i1_s2_q, ea_s1_q, ea_s2_q;
  reg div_q;
  reg [2:0] phase_q;
  reg [4:0] rst_cnt_q;
  reg dev_rst_q;
  reg ext_exec_q;
  reg [7:0] power_control_q;
  reg [7:0] cpu_ctrl_q;
  reg [1:0] mode_q;
  reg [31:0] settle_q;
  reg xdata_q;
  reg [7:0] cycle_q;
  wire tick;
  wire sys_rst;
  wire irq0_act, irq1_act, any_irq;
  wire ale_off;
  wire settled;
  reg [31:0] rd_d;
////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for pins
  // Only the second flop is read anywhere, never the first
  always @(posedge clk_in)
  begin
    rp_s1_q <= reset_pin_in;
    rp_s2_q <= rp_s1_q;
    i0_s1_q <= ext_irq_zero_n_in;
    i0_s2_q <= i0_s1_q;
    i1_s1_q <= ext_irq_one_n_in;
    i1_s2_q <= i1_s1_q;
    ea_s1_q <= external_fetch_select_in;
    ea_s2_q <= ea_s1_q;
  end

  // Divide-by-two enable, so clock duty cycle never matters
  always @(posedge clk_in)
  begin
    if (rst_in)
      div_q <= 1'b0;
    else if (osc_run_out)
      div_q <= ~div_q; // R15
  end
  assign tick = div_q & osc_run_out;

  // Six phases of two oscillator periods per machine cycle
  // Phase freezes with the oscillator, so a wake resumes mid-cycle
  always @(posedge clk_in)
  begin
    if (rst_in)
      phase_q <= 3'd0;
    else if (tick)
      phase_q <= (phase_q == LAST_PHASE) ? 3'd0 : phase_q + 3'd1;
  end

  // Reset pin must stay high 24 oscillator periods to take effect
  // A short glitch restarts the count, so noise cannot reset the core
  always @(posedge clk_in)
  begin
    if (rst_in || !rp_s2_q)
      rst_cnt_q <= 5'd0;
    else if (rst_cnt_q != RST_CYC)
      rst_cnt_q <= rst_cnt_q + 5'd1; // R1
  end
  always @(posedge clk_in)
  begin
    if (rst_in)
      dev_rst_q <= 1'b1;
    else
      dev_rst_q <= (rst_cnt_q == RST_CYC); // R1
  end
  assign sys_rst = rst_in | dev_rst_q;

  // Strap sampled during reset, frozen afterwards
  // A strap change after reset never moves the fetch source
  always @(posedge clk_in)
  begin
    if (sys_rst)
      ext_exec_q <= ~ea_s2_q; // R10 R11
  end
////////////////////////////////////////////////////////////////////////
  // Register bus, one wait cycle then answer
  // Writes land on the edge where waitrequest is low, as the master
  // holds everything until then; read data is loaded a cycle early
  always @(posedge clk_in)
  begin
    if (rst_in)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
  end

  // Read mux; unmapped offsets read zero
  always @*
  begin
    rd_d = 32'h0000_0000;
    case (avs_address)
      `PMBSC_REG_POWER_CONTROL: rd_d = {24'h00_0000, power_control_q};
      `PMBSC_REG_CPU_CTRL: rd_d = {24'h00_0000, cpu_ctrl_q};
      `PMBSC_REG_STATUS: rd_d = {27'h000_0000, dev_rst_q, ext_exec_q, settled, mode_q};
      `PMBSC_REG_CYCLE: rd_d = {24'h00_0000, cycle_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end
  // Read data captured while waiting, stands at the answer edge
  always @(posedge clk_in)
  begin
    if (rst_in)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & avs_waitrequest)
      avs_readdata <= rd_d;
  end

  // Power and cpu control writes; reset clears every field
  // Byte lane zero carries the whole register
  always @(posedge clk_in)
  begin
    if (sys_rst)
    begin
      power_control_q <= `PMBSC_PC_RESET; // R6 R20
      cpu_ctrl_q <= `PMBSC_CC_RESET;
    end
    else
    begin
      if (avs_write & ~avs_waitrequest & avs_byteenable[0])
      begin
        if (avs_address == `PMBSC_REG_POWER_CONTROL)
          power_control_q <= avs_writedata[7:0];
        if (avs_address == `PMBSC_REG_CPU_CTRL)
          cpu_ctrl_q <= avs_writedata[7:0];
      end
      // Mode bits self-clear on wake so the core resumes after them
      if (mode_q == MODE_WAKE && !any_irq)
        power_control_q[`PMBSC_PC_PDOWN] <= 1'b0; // R22
      if (mode_q == MODE_IDLE && any_irq)
        power_control_q[`PMBSC_PC_IDLE] <= 1'b0; // R17
    end
  end
////////////////////////////////////////////////////////////////////////
  assign irq0_act = ~i0_s2_q & cpu_ctrl_q[`PMBSC_CC_IRQ0_EN]; // R21
  assign irq1_act = ~i1_s2_q & cpu_ctrl_q[`PMBSC_CC_IRQ1_EN]; // R21
  assign any_irq = irq0_act | irq1_act;
  // Settle count only reports; the exit itself waits for the pin to rise,
  // so a user that releases early gets an unsettled clock
  assign settled = (settle_q >= SETTLE_CYC); // R23

  // Mode machine: idle, power-down, oscillator settle on wake
  // Mode bits stay set until the wake, so a read shows why the core stopped
  always @(posedge clk_in)
  begin
    if (sys_rst)
    begin
      mode_q <= MODE_RUN; // R17 R20
      settle_q <= 32'd0;
    end
    else
      case (mode_q)
        MODE_RUN:
        begin
          if (power_control_q[`PMBSC_PC_PDOWN])
            mode_q <= MODE_PDOWN; // R19
          else if (power_control_q[`PMBSC_PC_IDLE])
            mode_q <= MODE_IDLE; // R16
        end
        MODE_IDLE:
          if (any_irq)
            mode_q <= MODE_RUN; // R17
        MODE_PDOWN:
          if (any_irq)
          begin
            mode_q <= MODE_WAKE; // R21
            settle_q <= 32'd0;
          end
        MODE_WAKE:
        begin
          // Settle count runs while pin low; a user must hold it long enough
          if (settle_q < SETTLE_CYC)
            settle_q <= settle_q + 32'd1; // R23
          if (!any_irq)
            mode_q <= MODE_RUN; // R21
        end
        default: mode_q <= MODE_RUN;
      endcase
  end

  // Oscillator, core and wake controls
  // Core run drops one cycle after the mode changes, with the strobes
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      osc_run_out <= 1'b1;
      core_run_out <= 1'b0;
      core_reset_out <= 1'b1;
      wake_irq_out <= 1'b0;
      external_exec_out <= 1'b0;
    end
    else
    begin
      osc_run_out <= (mode_q != MODE_PDOWN); // R19 R21
      core_run_out <= (mode_q == MODE_RUN) & ~sys_rst; // R16
      core_reset_out <= sys_rst; // R20
      wake_irq_out <= (mode_q == MODE_WAKE) & ~any_irq; // R22
      external_exec_out <= ext_exec_q; // R11
    end
  end
////////////////////////////////////////////////////////////////////////
  // A data access occupies one machine cycle, starting at phase zero
  // A held access flag makes every machine cycle a data cycle
  always @(posedge clk_in)
  begin
    if (sys_rst)
      xdata_q <= 1'b0;
    else if (tick && phase_q == LAST_PHASE)
      xdata_q <= cpu_ctrl_q[`PMBSC_CC_XDATA] & (mode_q == MODE_RUN);
  end

  // Count machine cycles for software observation
  always @(posedge clk_in)
  begin
    if (sys_rst)
      cycle_q <= 8'h00;
    else if (tick && phase_q == LAST_PHASE)
      cycle_q <= cycle_q + 8'h01;
  end

  // Disable honoured only for internal code outside special cases
  // Bus strobes must come back whenever the core talks to memory
  assign ale_off = power_control_q[`PMBSC_PC_ALE_OFF] & ~ext_exec_q // R4 R7
    & ~cpu_ctrl_q[`PMBSC_CC_XDATA] & ~cpu_ctrl_q[`PMBSC_CC_CODE_RD] // R5
    & (mode_q == MODE_RUN); // R5

  // Strobes and ports, all registered
  // Idle keeps both strobes high so external memory stays deselected
  always @(posedge clk_in)
  begin
    if (sys_rst)
    begin
      address_latch_strobe_out <= 1'b1;
      ale_weak_pull_out <= 1'b0;
      program_fetch_strobe_n_out <= 1'b1;
      port_zero_out <= 8'hFF;
      port_zero_oe_n_out <= 8'hFF;
      port_two_out <= 8'hFF;
    end
    else if (mode_q == MODE_IDLE)
    begin
      address_latch_strobe_out <= 1'b1; // R18
      ale_weak_pull_out <= 1'b0; // R5
      program_fetch_strobe_n_out <= 1'b1; // R18
      // Open drain: ones float, zeros sink
      port_zero_oe_n_out <= ext_exec_q ? 8'hFF : port_zero_latch_in; // R18
      port_zero_out <= port_zero_latch_in;
      port_two_out <= ext_exec_q ? pc_addr_in[15:8] : port_two_latch_in; // R18
    end
    // Power-down and the settle wait look alike on the pins
    else if (mode_q != MODE_RUN)
    begin
      address_latch_strobe_out <= 1'b0; // R18
      ale_weak_pull_out <= 1'b0; // R5
      program_fetch_strobe_n_out <= 1'b0; // R18
      port_zero_oe_n_out <= ext_exec_q ? 8'hFF : port_zero_latch_in; // R18
      port_zero_out <= port_zero_latch_in;
      port_two_out <= port_two_latch_in; // R18
    end
    else
    begin
      // Strobe high in phases 0 and 3: two pulses per twelve periods
      address_latch_strobe_out <= ~ale_off & (phase_q == 3'd0 || phase_q == 3'd3)
        & ~(xdata_q & phase_q == 3'd0); // R2 R3
      ale_weak_pull_out <= ale_off; // R4
      // Fetch strobe low in phases 1-2 and 4-5 for external code
      program_fetch_strobe_n_out <= ~(ext_exec_q & phase_q != 3'd0 & phase_q != 3'd3
        & ~xdata_q); // R8 R9
      if (phase_q == 3'd0 || phase_q == 3'd3)
      begin
        // Low address byte, actively driven ones
        port_zero_oe_n_out <= 8'h00; // R12
        port_zero_out <= xdata_q ? (cpu_ctrl_q[`PMBSC_CC_WIDE] ?
          wide_pointer_reg_in[7:0] : indirect_index_reg_in) : pc_addr_in[7:0]; // R12
      end
      else if (xdata_q)
      begin
        port_zero_oe_n_out <= 8'h00; // R12
        port_zero_out <= write_data_in; // R12
      end
      else
      begin
        port_zero_oe_n_out <= ext_exec_q ? 8'hFF : port_zero_latch_in;
        port_zero_out <= port_zero_latch_in;
      end
      // High byte only for a wide pointer or a code fetch
      if (xdata_q)
        port_two_out <= cpu_ctrl_q[`PMBSC_CC_WIDE] ? wide_pointer_reg_in[15:8]
          : port_two_latch_in; // R13 R14
      else
        port_two_out <= ext_exec_q ? pc_addr_in[15:8] : port_two_latch_in; // R13
    end
  end
endmodule
`default_nettype wire

// >>> pmbsc_defines.vh
// Purpose: Constants for the power mode and bus strobe control block.
// Assumes: Avalon-MM word addressing by byte address, 32-bit data.
// Notes: Register offsets are byte addresses.
`ifndef PMBSC_DEFINES_VH
`define PMBSC_DEFINES_VH
// Register map
`define PMBSC_REG_POWER_CONTROL 8'h87
`define PMBSC_REG_CPU_CTRL 8'h88
`define PMBSC_REG_STATUS 8'h8C
`define PMBSC_REG_CYCLE 8'h90
// Power control fields
`define PMBSC_PC_IDLE 0
`define PMBSC_PC_PDOWN 1
`define PMBSC_PC_ALE_OFF 5
`define PMBSC_PC_RESET 8'h00
// Cpu control fields
`define PMBSC_CC_XDATA 0
`define PMBSC_CC_WIDE 1
`define PMBSC_CC_CODE_RD 2
`define PMBSC_CC_IRQ0_EN 3
`define PMBSC_CC_IRQ1_EN 4
`define PMBSC_CC_RESET 8'h00
// Phases per machine cycle (12 oscillator periods)
`define PMBSC_STATES 4'h6
`define PMBSC_LAST_PHASE 3'h5
// Reset pin high time in clocks, two machine cycles
`define PMBSC_RST_CYC 5'h18
// Oscillator settle time, us, and cycles at 200 MHz
`define PMBSC_SETTLE_US 10000
`define PMBSC_SETTLE_CYC (`PMBSC_SETTLE_US * 200)
`endif

// >>> pmbsc_ext_mem.sv
// Purpose: External memory side, latches the multiplexed address.
// Assumes: Address is caught on the strobe falling edge.
// Notes: Observes only; port zero has no read-back input.
`timescale 1ns/10ps
`default_nettype none
module pmbsc_ext_mem
(
  input wire logic clk_in, // Clock
  input wire logic strobe_in, // Address latch strobe
  input wire logic [7:0] p0_in, // Low address and data
  input wire logic [7:0] p2_in, // High address
  output logic [15:0] addr_q_out // Latched address
);
  logic [15:0] held_q;
  logic prev_q;
  // Like an external latch: keeps what stood while the strobe was high
  always @(posedge clk_in)
  begin
    held_q <= {p2_in, p0_in};
    prev_q <= strobe_in;
    if (prev_q && !strobe_in)
      addr_q_out <= held_q;
  end
endmodule
`default_nettype wire

// >>> pmbsc_properties.sv
// Purpose: Port-level timing checks of the strobe and mode control.
// Assumes: Single clock, synchronous active high reset.
// Notes: Mode transitions get a short grace window.
`timescale 1ns/10ps
`default_nettype none
module pmbsc_properties #(
  parameter SETTLE_CYC = 20
)
(
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic reset_pin_in, // Reset pin
  input wire logic avs_read, // Bus read
  input wire logic avs_write, // Bus write
  input wire logic avs_waitrequest, // Bus wait
  input wire logic address_latch_strobe_out, // Strobe
  input wire logic ale_weak_pull_out, // Weak pull
  input wire logic program_fetch_strobe_n_out, // Fetch strobe
  input wire logic core_run_out, // Core runs
  input wire logic osc_run_out, // Oscillator runs
  input wire logic core_reset_out, // Core reset
  input wire logic external_exec_out // External execution
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [5:0] pin_cnt_q;
  // Pin high run length, saturating so it never wraps
  always @(posedge clk_in)
    pin_cnt_q <= !reset_pin_in ? 6'h0 : pin_cnt_q + {5'h0, pin_cnt_q != 6'h3f};
  sequence seq_pulse2;
    (address_latch_strobe_out || !core_run_out)
      ##1 (!address_latch_strobe_out || !core_run_out);
  endsequence
  AST_PIN_RESET: assert property (pin_cnt_q >= 6'd32 |-> core_reset_out)
    else $error("reset pin held but no reset");
  AST_STROBE_WIDTH: assert property ($rose(address_latch_strobe_out) && core_run_out
    && $past(core_run_out) && !$past(ale_weak_pull_out) && !core_reset_out
    |-> ##1 seq_pulse2) else $error("strobe width wrong");
  AST_PULL_QUIET: assert property (ale_weak_pull_out && $past(ale_weak_pull_out)
    |-> !address_latch_strobe_out) else $error("strobe while disabled");
  AST_RESET_NO_PULL: assert property (core_reset_out |-> !ale_weak_pull_out)
    else $error("pull during reset");
  AST_EXT_NO_PULL: assert property (external_exec_out |-> !ale_weak_pull_out)
    else $error("pull in external execution");
  AST_INT_NO_FETCH: assert property (!external_exec_out && core_run_out
    && $past(core_run_out) |-> program_fetch_strobe_n_out)
    else $error("fetch strobe in internal execution");
  AST_STRAP_HELD: assert property (!core_reset_out && $past(!core_reset_out)
    |-> $stable(external_exec_out)) else $error("strap latch moved");
  AST_IDLE_HIGH: assert property ($fell(core_run_out) && osc_run_out && !core_reset_out
    |-> ##[0:2] ((address_latch_strobe_out && program_fetch_strobe_n_out) || !osc_run_out))
    else $error("idle strobes not high");
  AST_PDOWN_LOW: assert property ($fell(osc_run_out) && !core_reset_out
    |-> ##[0:2] (!address_latch_strobe_out && !program_fetch_strobe_n_out))
    else $error("power-down strobes not low");
  AST_BUS_WAIT: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule
`default_nettype wire

// >>> pmbsc_top_tb.sv
// Purpose: Self-checking bench for strobe, strap and power modes.
// Assumes: Register bus answers whenever waitrequest drops.
// Notes: Counts use 120-clock windows, a whole number of machine cycles.
`timescale 1ns/10ps
`default_nettype none
module pmbsc_top_tb;
  logic clk_in, rst_in, pin, strap, irq0_n, irq1_n, rd, wr, wq, stb, pull, fet_n;
  logic run, osc, crst, wake, ext;
  logic [15:0] pc, wide, exp_addr, mem_addr;
  logic [7:0] idx, p2l, p0l, wdat, adr, p0, p0oe, p2;
  logic [31:0] wd, rdata, q;
  logic [3:0] be;
  int seed, mismatches, checked, cyc, s, f, h, wk;
  pmbsc_top #(.SETTLE_CYC(20)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .reset_pin_in(pin), .external_fetch_select_in(strap), .ext_irq_zero_n_in(irq0_n),
    .ext_irq_one_n_in(irq1_n), .pc_addr_in(pc), .wide_pointer_reg_in(wide),
    .indirect_index_reg_in(idx), .port_two_latch_in(p2l), .port_zero_latch_in(p0l),
    .write_data_in(wdat), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wq),
    .address_latch_strobe_out(stb), .ale_weak_pull_out(pull),
    .program_fetch_strobe_n_out(fet_n), .port_zero_out(p0), .port_zero_oe_n_out(p0oe),
    .port_two_out(p2), .core_run_out(run), .osc_run_out(osc), .core_reset_out(crst),
    .wake_irq_out(wake), .external_exec_out(ext));
  pmbsc_ext_mem i_mem (.clk_in(clk_in), .strobe_in(stb), .p0_in(p0), .p2_in(p2),
    .addr_q_out(mem_addr));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock 200 MHz
  initial
  begin
    clk_in = 0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Hang guard, far above the expected run length
  always @(posedge clk_in)
  begin
    cyc++;
    wk += (wake === 1'b1); // One-cycle wake pulses
    if (cyc == 20000)
    begin
      mismatches++;
      final_report;
    end
  end
  function int exp_stb(input bit data);
    return data ? 10 : 20;
  endfunction
  function int exp_fet(input bit ex, input bit data);
    return (ex && !data) ? 20 : 0;
  endfunction
  task final_report;
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge clk_in); while (wq !== 1'b0);
    q = rdata;
    rd <= 0;
    wr <= 0;
  endtask
  task wset(input logic [7:0] a, input logic [31:0] d);
    bus(1, a, d);
    repeat (24) @(posedge clk_in);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 0);
    check("readdata", q, e);
  endtask
  task watch;
    logic ps, pf;
    s = 0; f = 0; h = 0; ps = stb; pf = fet_n;
    repeat (120)
    begin
      @(posedge clk_in);
      s += (stb && !ps);
      f += (!fet_n && pf);
      h += (mem_addr === exp_addr);
      ps = stb; pf = fet_n;
    end
  endtask
  // Reset pin held high for n clocks; 40 gives a device reset, 10 does not
  task pin_reset(input int n);
    pin <= 1;
    repeat (n) @(posedge clk_in);
    pin <= 0;
    repeat (100) if (crst !== 1'b0) @(posedge clk_in);
    repeat (4) @(posedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 24576; mismatches = 0; checked = 0; cyc = 0; rst_in = 1; pin = 0; strap = 1;
    irq0_n = 1; irq1_n = 1; rd = 0; wr = 0; adr = 0; wd = 0; be = 4'hf; exp_addr = 0;
    pc = $random(seed); wide = $random(seed); idx = $random(seed); p2l = $random(seed);
    p0l = $random(seed); wdat = $random(seed);
    wk = 0;
    repeat (10) @(posedge clk_in);
    rst_in <= 0;
    repeat (24) @(posedge clk_in);
    watch;
    check("strobes", s, exp_stb(0));
    check("fetches", f, exp_fet(0, 0));
    wset(8'h87, 32'h20);
    watch;
    check("strobes", s, 0);
    check("pull", pull, 1);
    rchk(8'h87, 32'h20);
    wset(8'h88, 32'h04);
    watch;
    check("strobes", s, exp_stb(0));
    check("pull", pull, 0);
    exp_addr = wide;
    wset(8'h88, 32'h03);
    watch;
    check("strobes", s, exp_stb(1));
    check("wide hit", h != 0, 1);
    exp_addr = {p2l, idx};
    wset(8'h88, 32'h01);
    watch;
    check("index hit", h != 0, 1);
    strap <= 0;
    pin_reset(40);
    strap <= 1;
    exp_addr = pc;
    check("ext", ext, 1);
    rchk(8'h87, 32'h00);
    watch;
    check("fetches", f, exp_fet(1, 0));
    check("pc hit", h != 0, 1);
    check("ext", ext, 1);
    wset(8'h87, 32'h20);
    watch;
    check("strobes", s, exp_stb(0));
    check("pull", pull, 0);
    wset(8'h88, 32'h01);
    watch;
    check("fetches", f, exp_fet(1, 1));
    check("strobes", s, exp_stb(1));
    wset(8'h88, 32'h08);
    wset(8'h87, 32'h01);
    check("run", run, 0);
    check("idle strobes", {stb, fet_n}, 2'b11);
    check("idle port0", p0oe, 8'hFF);
    check("idle port2", p2, pc[15:8]);
    rchk(8'h88, 32'h08);
    irq0_n <= 0;
    repeat (300) if (run !== 1'b1) @(posedge clk_in);
    check("run", run, 1);
    irq0_n <= 1;
    wset(8'h87, 32'h22);
    check("osc", osc, 0);
    check("pd pins", {stb, fet_n, pull}, 3'b000);
    check("pd port0", p0oe, 8'hFF);
    check("pd port2", p2, p2l);
    irq0_n <= 0;
    repeat (300) if (osc !== 1'b1) @(posedge clk_in);
    check("osc", osc, 1);
    repeat (40) @(posedge clk_in);
    check("run", run, 0);
    irq0_n <= 1;
    repeat (300) if (run !== 1'b1) @(posedge clk_in);
    check("run", run, 1);
    check("wake", wk, 1);
    rchk(8'h88, 32'h08);
    rchk(8'h87, 32'h20);
    rchk(8'h8C, 32'h0C);
    pin_reset(10);
    rchk(8'h88, 32'h08);
    wset(8'h87, 32'h02);
    pin_reset(40);
    check("osc", osc, 1);
    rchk(8'h88, 32'h00);
    rchk(8'h40, 32'h00);
    final_report;
  end
endmodule
bind pmbsc_top pmbsc_properties #(.SETTLE_CYC(SETTLE_CYC)) i_props (.clk_in(clk_in),
  .rst_in(rst_in), .reset_pin_in(reset_pin_in), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .address_latch_strobe_out(address_latch_strobe_out), .ale_weak_pull_out(ale_weak_pull_out),
  .program_fetch_strobe_n_out(program_fetch_strobe_n_out), .core_run_out(core_run_out),
  .osc_run_out(osc_run_out), .core_reset_out(core_reset_out),
  .external_exec_out(external_exec_out));
`default_nettype wire
